// ### rtl/xor_tab_pkg.sv
// Constants for the exclusive-OR and table-read execution block
package xor_tab_pkg;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int ROM_W = 14;
  localparam int ROM_AW = 12;
  localparam int HI_W = ROM_W - DATA_W;
  // Opcode patterns (14-bit instruction word)
  localparam logic [5:0] OP_XOR_LIT = 6'h1f;
  localparam logic [5:0] OP_XOR_FILE = 6'h06;
  localparam logic [13:0] OP_TAB_LOW = 14'h0050;
  localparam logic [13:0] OP_TAB_HIGH = 14'h0051;
  // Data-space addresses of the pointer registers (choice)
  localparam logic [6:0] ADDR_PTR_LOW = 7'h0c;
  localparam logic [6:0] ADDR_PTR_HIGH = 7'h0d;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int TAB_CYCLES = 2;
endpackage : xor_tab_pkg

// ### rtl/prog_rom.sv
// Program ROM with a registered read port and a write port for loading
`timescale 1ns/1ns
`default_nettype none
module prog_rom #(
  parameter int AW = 12,
  parameter int DW = 14
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : prog_rom
`default_nettype wire

// ### rtl/xor_tab_exec.sv
// Execution of exclusive-OR and table-read instructions
// Summary of operation
// - Literal XOR into accumulator, zero flag, one cycle
// - Accumulator XOR data register, zero flag, one cycle
// - Destination bit picks accumulator or data register
// - Low read loads low ROM byte at pointer
// - Low read increments full pointer with carry
// - Table reads take two cycles, no operand
// - High read loads high ROM byte
// - Pointer halves are writable data registers
`timescale 1ns/1ns
`default_nettype none
module xor_tab_exec #(
  parameter int ROM_AW = xor_tab_pkg::ROM_AW
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Instruction issue
  input wire logic INSTR_VALID_I,
  input wire logic [13:0] INSTR_I,
  output logic BUSY_O,
  output logic DONE_O,
  // Data register port: read data for the addressed register
  input wire logic [7:0] FILE_RDATA_I,
  output logic FILE_WE_O,
  output logic [6:0] FILE_WADDR_O,
  output logic [7:0] FILE_WDATA_O,
  // Move-instruction writes into the data space
  input wire logic MOVE_WE_I,
  input wire logic [6:0] MOVE_ADDR_I,
  input wire logic [7:0] MOVE_DATA_I,
  // Program ROM loading
  input wire logic ROM_WE_I,
  input wire logic [ROM_AW-1:0] ROM_WADDR_I,
  input wire logic [13:0] ROM_WDATA_I,
  // Core state
  output logic [7:0] ACC_O,
  output logic ZERO_O,
  output logic [7:0] PTR_LOW_O,
  output logic [7:0] PTR_HIGH_O
);
  typedef enum {S_IDLE, S_FETCH} state_t;
  state_t state_q, state_d;
  logic high_q, high_d;
  logic busy_q, busy_d;
  logic [7:0] acc_q, acc_d, plo_q, plo_d, phi_q, phi_d;
  logic zero_q, zero_d, done_q, done_d;
  logic fwe_q, fwe_d;
  logic [6:0] fwa_q, fwa_d;
  logic [7:0] fwd_q, fwd_d;
  logic [13:0] rom_q;
  logic [ROM_AW-1:0] rom_addr;
  logic [15:0] ptr_inc;
  logic [7:0] xr;

  // Pointer = high bits above low byte
  assign rom_addr = ROM_AW'({phi_q, plo_q});
  assign ptr_inc = {phi_q, plo_q} + 16'h0001;
  assign xr = acc_q ^ FILE_RDATA_I;

  prog_rom #(.AW(ROM_AW), .DW(xor_tab_pkg::ROM_W)) u_rom (
    .clk_i(MCLK_I),
    .we_i(ROM_WE_I),
    .waddr_i(ROM_WADDR_I),
    .wdata_i(ROM_WDATA_I),
    .raddr_i(rom_addr),
    .rdata_o(rom_q)
  );

  always_comb begin
    state_d = state_q;
    high_d = high_q;
    acc_d = acc_q;
    plo_d = plo_q;
    phi_d = phi_q;
    zero_d = zero_q;
    done_d = 1'b0;
    fwe_d = 1'b0;
    fwa_d = fwa_q;
    fwd_d = fwd_q;
    // Move writes land in the pointer registers
    if (MOVE_WE_I && MOVE_ADDR_I == xor_tab_pkg::ADDR_PTR_LOW) begin
      plo_d = MOVE_DATA_I;
    end
    if (MOVE_WE_I && MOVE_ADDR_I == xor_tab_pkg::ADDR_PTR_HIGH) begin
      phi_d = MOVE_DATA_I;
    end
    unique case (state_q)
      S_IDLE: begin
        if (INSTR_VALID_I) begin
          if (INSTR_I[13:8] == xor_tab_pkg::OP_XOR_LIT) begin
            acc_d = acc_q ^ INSTR_I[7:0];
            zero_d = ((acc_q ^ INSTR_I[7:0]) == 8'h00);
            done_d = 1'b1;
          end else if (INSTR_I[13:8] == xor_tab_pkg::OP_XOR_FILE) begin
            zero_d = (xr == 8'h00);
            done_d = 1'b1;
            if (INSTR_I[7] == xor_tab_pkg::DEST_ACC) begin
              acc_d = xr;
            end else begin
              fwe_d = 1'b1;
              fwa_d = INSTR_I[6:0];
              fwd_d = xr;
            end
          end else if (INSTR_I == xor_tab_pkg::OP_TAB_LOW
                       || INSTR_I == xor_tab_pkg::OP_TAB_HIGH) begin
            // ROM read is registered, so the second cycle picks up the word
            high_d = INSTR_I[0];
            state_d = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        state_d = S_IDLE;
        done_d = 1'b1;
        if (high_q) begin
          acc_d = {2'b00, rom_q[13:8]};
        end else begin
          acc_d = rom_q[7:0];
          // A move write in this cycle loses to the increment
          plo_d = ptr_inc[7:0];
          phi_d = ptr_inc[15:8];
        end
      end
    endcase
    // Busy is registered so the port comes straight from a flop
    busy_d = (state_d == S_FETCH);
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
      high_q <= 1'b0;
      acc_q <= xor_tab_pkg::ACC_RESET;
      plo_q <= xor_tab_pkg::PTR_RESET;
      phi_q <= xor_tab_pkg::PTR_RESET;
      zero_q <= 1'b0;
      done_q <= 1'b0;
      fwe_q <= 1'b0;
      fwa_q <= 7'h00;
      fwd_q <= 8'h00;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      high_q <= high_d;
      acc_q <= acc_d;
      plo_q <= plo_d;
      phi_q <= phi_d;
      zero_q <= zero_d;
      done_q <= done_d;
      fwe_q <= fwe_d;
      fwa_q <= fwa_d;
      fwd_q <= fwd_d;
    end
  end

  assign BUSY_O = busy_q;
  assign DONE_O = done_q;
  assign FILE_WE_O = fwe_q;
  assign FILE_WADDR_O = fwa_q;
  assign FILE_WDATA_O = fwd_q;
  assign ACC_O = acc_q;
  assign ZERO_O = zero_q;
  assign PTR_LOW_O = plo_q;
  assign PTR_HIGH_O = phi_q;

  AST_XOR_LIT: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_LIT)
    |=> (ACC_O == ($past(ACC_O) ^ $past(INSTR_I[7:0]))) && DONE_O)
    else $error("literal xor result wrong");
  AST_XOR_ZERO: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_FILE)
    |=> ZERO_O == ($past(ACC_O ^ FILE_RDATA_I) == 8'h00))
    else $error("file xor zero flag wrong");
  AST_XOR_DEST: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_FILE && INSTR_I[7])
    |=> FILE_WE_O && $stable(ACC_O))
    else $error("file destination not honoured");
  AST_TAB_TWO: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && (INSTR_I == xor_tab_pkg::OP_TAB_LOW))
    |=> BUSY_O ##1 (!BUSY_O && DONE_O))
    else $error("table read not two cycles");
  AST_PTR_INC: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (BUSY_O && !high_q) |=> {PTR_HIGH_O, PTR_LOW_O} == $past({PTR_HIGH_O, PTR_LOW_O}) + 16'h0001)
    else $error("pointer not incremented");
  AST_PTR_HOLD: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (BUSY_O && high_q && !MOVE_WE_I) |=> $stable({PTR_HIGH_O, PTR_LOW_O}))
    else $error("high read moved pointer");
  AST_HIGH_ZERO: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (BUSY_O && high_q) |=> ACC_O[7:6] == 2'b00 && ACC_O[5:0] == $past(rom_q[13:8]))
    else $error("high byte wrong");
  AST_LOW_LOAD: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (BUSY_O && !high_q) |=> ACC_O == $past(rom_q[7:0]))
    else $error("low byte wrong");
  AST_MOVE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && MOVE_WE_I && MOVE_ADDR_I == xor_tab_pkg::ADDR_PTR_LOW) |=> PTR_LOW_O == $past(MOVE_DATA_I))
    else $error("pointer move lost");
  AST_MOVE_HIGH: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && MOVE_WE_I && MOVE_ADDR_I == xor_tab_pkg::ADDR_PTR_HIGH) |=> PTR_HIGH_O == $past(MOVE_DATA_I))
    else $error("pointer high move lost");
  // Completion, refusal and write-back checks
  AST_FETCH_END: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    BUSY_O |=> !BUSY_O && DONE_O && !FILE_WE_O)
    else $error("table read did not end");
  AST_UNKNOWN_IGNORED: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] != xor_tab_pkg::OP_XOR_LIT
     && INSTR_I[13:8] != xor_tab_pkg::OP_XOR_FILE && INSTR_I != xor_tab_pkg::OP_TAB_LOW
     && INSTR_I != xor_tab_pkg::OP_TAB_HIGH) |=> !DONE_O && !BUSY_O && $stable(ACC_O))
    else $error("unknown code was executed");
  AST_LIT_NO_WRITE: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_LIT) |=> !FILE_WE_O && !BUSY_O)
    else $error("literal xor touched the data space");
  AST_XOR_ACC: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_FILE && !INSTR_I[7])
    |=> ACC_O == $past(ACC_O ^ FILE_RDATA_I) && DONE_O && !FILE_WE_O)
    else $error("accumulator destination not honoured");
  AST_FILE_TARGET: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && INSTR_VALID_I && INSTR_I[13:8] == xor_tab_pkg::OP_XOR_FILE && INSTR_I[7])
    |=> FILE_WADDR_O == $past(INSTR_I[6:0]) && FILE_WDATA_O == $past(ACC_O ^ FILE_RDATA_I))
    else $error("file write-back wrong");
  AST_DONE_QUIET: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (!BUSY_O && !INSTR_VALID_I) |=> !DONE_O && !FILE_WE_O && $stable(ACC_O))
    else $error("completion without an instruction");
endmodule : xor_tab_exec
`default_nettype wire

// ### tb/xor_tab_exec_tb.sv
// Self-checking bench for the exclusive-OR and table-read block
`timescale 1ns/1ns
`default_nettype none
module xor_tab_exec_tb;
  logic MCLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic INSTR_VALID_I = 1'b0;
  logic [13:0] INSTR_I = 14'h0000;
  logic [7:0] FILE_RDATA_I = 8'h00;
  logic MOVE_WE_I = 1'b0;
  logic [6:0] MOVE_ADDR_I = 7'h00;
  logic [7:0] MOVE_DATA_I = 8'h00;
  logic ROM_WE_I = 1'b0;
  logic [11:0] ROM_WADDR_I = 12'h000;
  logic [13:0] ROM_WDATA_I = 14'h0000;
  logic BUSY_O, DONE_O, FILE_WE_O, ZERO_O;
  logic [6:0] FILE_WADDR_O;
  logic [7:0] FILE_WDATA_O, ACC_O, PTR_LOW_O, PTR_HIGH_O;
  int bad_count = 0;
  int check_count = 0;
  always #5 MCLK_I = ~MCLK_I;
  xor_tab_exec DUT (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .INSTR_VALID_I(INSTR_VALID_I),
    .INSTR_I(INSTR_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .FILE_RDATA_I(FILE_RDATA_I),
    .FILE_WE_O(FILE_WE_O), .FILE_WADDR_O(FILE_WADDR_O), .FILE_WDATA_O(FILE_WDATA_O),
    .MOVE_WE_I(MOVE_WE_I), .MOVE_ADDR_I(MOVE_ADDR_I), .MOVE_DATA_I(MOVE_DATA_I),
    .ROM_WE_I(ROM_WE_I), .ROM_WADDR_I(ROM_WADDR_I), .ROM_WDATA_I(ROM_WDATA_I),
    .ACC_O(ACC_O), .ZERO_O(ZERO_O), .PTR_LOW_O(PTR_LOW_O), .PTR_HIGH_O(PTR_HIGH_O));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // A literal XOR offered in the busy cycle must be ignored
  task automatic exec(input logic [13:0] ins, input int cyc);
    @(negedge MCLK_I);
    INSTR_VALID_I = 1'b1;
    INSTR_I = ins;
    @(negedge MCLK_I);
    INSTR_I = 14'h1fff;
    INSTR_VALID_I = (cyc == xor_tab_pkg::TAB_CYCLES);
    if (cyc == xor_tab_pkg::TAB_CYCLES) begin
      chk({DONE_O, BUSY_O}, 8'h01);
      @(negedge MCLK_I);
      INSTR_VALID_I = 1'b0;
    end
    chk({DONE_O, BUSY_O}, 8'h02);
  endtask : exec
  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge MCLK_I);
    MOVE_WE_I = 1'b1;
    MOVE_ADDR_I = xor_tab_pkg::ADDR_PTR_LOW;
    MOVE_DATA_I = lo;
    @(negedge MCLK_I);
    MOVE_ADDR_I = xor_tab_pkg::ADDR_PTR_HIGH;
    MOVE_DATA_I = hi;
    @(negedge MCLK_I);
    MOVE_WE_I = 1'b0;
    chk(PTR_LOW_O, lo);
    chk(PTR_HIGH_O, hi);
  endtask : set_ptr
  task automatic rom_put(input logic [11:0] a, input logic [13:0] d);
    @(negedge MCLK_I);
    ROM_WE_I = 1'b1;
    ROM_WADDR_I = a;
    ROM_WDATA_I = d;
    @(negedge MCLK_I);
    ROM_WE_I = 1'b0;
  endtask : rom_put
  task automatic test_xor();
    exec(14'h1fb5, 1);
    chk(ACC_O, 8'hb5);
    chk({7'h00, ZERO_O}, 8'h00);
    exec(14'h1fb5, 1);
    chk(ACC_O, 8'h00);
    chk({7'h00, ZERO_O}, 8'h01);
    exec(14'h1fb5, 1);
    chk(ACC_O, 8'hb5);
    FILE_RDATA_I = 8'haf;
    exec(14'h0621, 1);
    chk(ACC_O, 8'h1a);
    chk({ZERO_O, FILE_WE_O}, 8'h00);
    exec(14'h06a1, 1);
    chk({FILE_WE_O, FILE_WADDR_O}, 8'ha1);
    chk(FILE_WDATA_O, 8'hb5);
    chk(ACC_O, 8'h1a);
    chk({7'h00, ZERO_O}, 8'h00);
    FILE_RDATA_I = 8'h1a;
    exec(14'h0621, 1);
    chk(ACC_O, 8'h00);
    chk({7'h00, ZERO_O}, 8'h01);
    chk({7'h00, FILE_WE_O}, 8'h00);
    $display("xor tests finished");
  endtask : test_xor
  // Codes outside the four are ignored and leave the accumulator alone
  task automatic test_refuse();
    exec(14'h1f5a, 1);
    chk(ACC_O, 8'h5a);
    @(negedge MCLK_I);
    INSTR_VALID_I = 1'b1;
    INSTR_I = 14'h0052;
    @(negedge MCLK_I);
    INSTR_I = 14'h1e5a;
    chk({6'h00, DONE_O, BUSY_O}, 8'h00);
    @(negedge MCLK_I);
    INSTR_VALID_I = 1'b0;
    chk({6'h00, DONE_O, BUSY_O}, 8'h00);
    chk(ACC_O, 8'h5a);
    $display("refuse tests finished");
  endtask : test_refuse
  // A reset that cuts a table read leaves no late completion behind
  task automatic test_reset();
    set_ptr(8'h02, 8'h34);
    @(negedge MCLK_I);
    INSTR_VALID_I = 1'b1;
    INSTR_I = xor_tab_pkg::OP_TAB_LOW;
    @(negedge MCLK_I);
    INSTR_VALID_I = 1'b0;
    RESET_I = 1'b1;
    repeat (2) @(negedge MCLK_I);
    RESET_I = 1'b0;
    chk({6'h00, DONE_O, BUSY_O}, 8'h00);
    chk(ACC_O | PTR_LOW_O | PTR_HIGH_O, 8'h00);
    @(negedge MCLK_I);
    chk({6'h00, DONE_O, BUSY_O}, 8'h00);
    set_ptr(8'h02, 8'h34);
    exec(14'h0050, 2);
    chk(ACC_O, 8'h89);
    chk(PTR_LOW_O, 8'h35);
    $display("reset test finished");
  endtask : test_reset
  // Two adjacent words each read high then low, then a carry across the low byte
  task automatic test_table();
    rom_put(12'h234, 14'h3789);
    rom_put(12'h235, 14'h2277);
    rom_put(12'h1ff, 14'h3f00);
    set_ptr(8'h02, 8'h34);
    exec(14'h0051, 2);
    chk(ACC_O, 8'h37);
    chk(PTR_LOW_O, 8'h34);
    exec(14'h0050, 2);
    chk(ACC_O, 8'h89);
    chk(PTR_LOW_O, 8'h35);
    exec(14'h0051, 2);
    chk(ACC_O, 8'h22);
    exec(14'h0050, 2);
    chk(ACC_O, 8'h77);
    set_ptr(8'h01, 8'hff);
    exec(14'h0051, 2);
    chk(ACC_O, 8'h3f);
    exec(14'h0050, 2);
    chk({ACC_O[3:0], PTR_HIGH_O[3:0]}, 8'h02);
    chk(PTR_LOW_O, 8'h00);
    $display("table tests finished");
  endtask : test_table
  initial begin
    repeat (8) @(negedge MCLK_I);
    RESET_I = 1'b0;
    chk(ACC_O | PTR_LOW_O | PTR_HIGH_O, 8'h00);
    test_xor();
    test_refuse();
    test_table();
    test_reset();
    complete_run();
  end
  // Whole run is about 70 cycles
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule : xor_tab_exec_tb
`default_nettype wire
